// ---- bench/lbs_decode_model.sv ----
// Static decode of the memory identity seen on the bus into cycle inputs.
// Assumes the bench presents the memory identity and completion requests.
`timescale 1ns/1ps
`include "lbs_regs.svh"
module lbs_decode_model (
   input wire logic memSel,
   input wire logic retryReq,
   input wire logic readyReq,
   input wire logic faultReq,
   output logic [`LBS_ADDR_SHIFT_W-1:0] addressShiftSelect,
   output logic [`LBS_BUS_SIZE_W-1:0] busSizeSelect,
   output logic [`LBS_CYCLE_TIMING_W-1:0] cycleTimingSelect,
   output logic [`LBS_PAGE_SIZE_W-1:0] pageSizeSelect,
   output logic retryIn,
   output logic readyIn,
   output logic faultIn
);
   always_comb begin
      addressShiftSelect = memSel ? 2'h1 : 2'h2;
      busSizeSelect = memSel ? 2'h0 : 2'h3;
      cycleTimingSelect = memSel ? 3'h5 : `LBS_CYC_TIMING_TWO;
      pageSizeSelect = memSel ? 4'h9 : 4'h6;
      retryIn = retryReq;
      readyIn = readyReq;
      faultIn = faultReq;
   end
endmodule : lbs_decode_model

// ---- bench/local_bus_strap_and_cycle_sampling_tb_top.sv ----
// Self-checking bench for strap capture and cycle input sampling.
// Assumes lbs_sampler and the decode model; inputs change 1 ns after the edge.
`timescale 1ns/1ps
`include "lbs_regs.svh"
`define CHK(nm, ex, ac) begin checkCount++; if ((ac) !== (ex)) begin nErrors++; \
   $display("Error %s expected %h seen %h", nm, ex, ac); end end
module local_bus_strap_and_cycle_sampling_tb_top;
   logic sys_clk = 1'b0, rst = 1'b1, resetPin_n = 1'b1, hostRequestStrap_n = 1'b1;
   logic userTimingInput_n = 1'b1, memSel = 1'b0, retryReq = 1'b0, readyReq = 1'b0;
   logic faultReq = 1'b0, accessStart = 1'b0, colStart = 1'b0;
   logic [`LBS_ADDR_SHIFT_W-1:0] addressShiftSelect, addrShiftCfg;
   logic [`LBS_BUS_SIZE_W-1:0] busSizeSelect, busSizeCfg;
   logic [`LBS_CYCLE_TIMING_W-1:0] cycleTimingSelect, cycleTimingCfg;
   logic [`LBS_PAGE_SIZE_W-1:0] pageSizeSelect, pageSizeCfg;
   logic retryIn, readyIn, faultIn, outputClock, selfBootstrap, bigEndian, rowStateTwo;
   logic userTimingCfg, retrySeen, readySeen, faultSeen, cfgValid;
   int nErrors = 0, checkCount = 0;
   always #5 sys_clk = ~sys_clk;
   lbs_decode_model PARTNER (.memSel(memSel), .retryReq(retryReq), .readyReq(readyReq),
      .faultReq(faultReq), .addressShiftSelect(addressShiftSelect), .busSizeSelect(busSizeSelect),
      .cycleTimingSelect(cycleTimingSelect), .pageSizeSelect(pageSizeSelect),
      .retryIn(retryIn), .readyIn(readyIn), .faultIn(faultIn));
   lbs_sampler #(.ROW_STATES(6)) DUT (.sys_clk(sys_clk), .rst(rst), .resetPin_n(resetPin_n),
      .hostRequestStrap_n(hostRequestStrap_n), .userTimingInput_n(userTimingInput_n),
      .addressShiftSelect(addressShiftSelect), .busSizeSelect(busSizeSelect),
      .cycleTimingSelect(cycleTimingSelect), .pageSizeSelect(pageSizeSelect),
      .retryIn(retryIn), .readyIn(readyIn), .faultIn(faultIn), .accessStart(accessStart),
      .colStart(colStart), .outputClock(outputClock), .selfBootstrap(selfBootstrap),
      .bigEndian(bigEndian), .rowStateTwo(rowStateTwo), .addrShiftCfg(addrShiftCfg),
      .busSizeCfg(busSizeCfg), .cycleTimingCfg(cycleTimingCfg), .pageSizeCfg(pageSizeCfg),
      .userTimingCfg(userTimingCfg), .retrySeen(retrySeen), .readySeen(readySeen),
      .faultSeen(faultSeen), .cfgValid(cfgValid));
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   // pin reset with strap levels held through the rise
   task automatic pin_reset(input logic hr, input logic ut, input int lowLen);
      hostRequestStrap_n = hr;
      userTimingInput_n = ut;
      resetPin_n = 1'b0;
      tick(lowLen);
      resetPin_n = 1'b1;
      tick(8);
   endtask : pin_reset
   task automatic test_straps;
      pin_reset(1'b0, 1'b0, 10);
      `CHK("selfBootstrap", 1'b1, selfBootstrap)
      `CHK("bigEndian", 1'b1, bigEndian)
      pin_reset(1'b1, 1'b1, 3);
      `CHK("selfBootstrap", 1'b1, selfBootstrap)
      `CHK("bigEndian", 1'b1, bigEndian)
      pin_reset(1'b0, 1'b1, 6);
      `CHK("selfBootstrap", 1'b1, selfBootstrap)
      `CHK("bigEndian", 1'b0, bigEndian)
      tick(20);
      `CHK("bigEndian", 1'b0, bigEndian)
      $display("test_straps done");
   endtask : test_straps
   task automatic test_clock;
      logic prev;
      prev = outputClock;
      for (int i = 0; i < 6; i++) begin
         tick(1);
         `CHK("outputClock", ~prev, outputClock)
         prev = outputClock;
      end
      $display("test_clock done");
   endtask : test_clock
   task automatic test_access;
      int w;
      memSel = 1'b0;
      faultReq = 1'b1;
      retryReq = 1'b0;
      colStart = 1'b1;
      tick(4);
      if (outputClock !== 1'b1) tick(1);
      // start aligned to output clock high
      accessStart = 1'b1;
      tick(1);
      accessStart = 1'b0;
      w = 0;
      while (cfgValid !== 1'b1 && w < 20) begin tick(1); w++; end
      `CHK("cfgValid", 1'b1, cfgValid)
      `CHK("addrShiftCfg", 2'h2, addrShiftCfg)
      `CHK("busSizeCfg", 2'h3, busSizeCfg)
      `CHK("cycleTimingCfg", `LBS_CYC_TIMING_TWO, cycleTimingCfg)
      `CHK("pageSizeCfg", 4'h6, pageSizeCfg)
      `CHK("userTimingCfg", 1'b1, userTimingCfg)
      `CHK("rowStateTwo", 1'b1, rowStateTwo)
      memSel = 1'b1;
      tick(8);
      `CHK("faultSeen", 1'b1, faultSeen)
      `CHK("pageSizeCfg", 4'h6, pageSizeCfg)
      `CHK("cycleTimingCfg", `LBS_CYC_TIMING_TWO, cycleTimingCfg)
      retryReq = 1'b1;
      readyReq = 1'b1;
      tick(8);
      `CHK("retrySeen", 1'b1, retrySeen)
      `CHK("readySeen", 1'b1, readySeen)
      $display("test_access done");
   endtask : test_access
   // strap low too briefly before reset rise
   task automatic test_strap_setup;
      hostRequestStrap_n = 1'b1;
      userTimingInput_n = 1'b1;
      resetPin_n = 1'b0;
      tick(8);
      hostRequestStrap_n = 1'b0;
      tick(2);
      resetPin_n = 1'b1;
      tick(8);
      `CHK("selfBootstrap", 1'b0, selfBootstrap)
      `CHK("bigEndian", 1'b0, bigEndian)
      $display("test_strap_setup done");
   endtask : test_strap_setup
   // Single-cycle column timing: ready only at row three
   task automatic test_fast_access;
      int w;
      readyReq = 1'b0;
      retryReq = 1'b0;
      tick(4);
      if (outputClock !== 1'b1) tick(1);
      accessStart = 1'b1;
      tick(1);
      accessStart = 1'b0;
      w = 0;
      while (rowStateTwo !== 1'b1 && w < 20) begin tick(1); w++; end
      `CHK("rowStateTwo", 1'b1, rowStateTwo)
      `CHK("cycleTimingCfg", 3'h5, cycleTimingCfg)
      `CHK("pageSizeCfg", 4'h9, pageSizeCfg)
      readyReq = 1'b1;
      retryReq = 1'b1;
      tick(8);
      `CHK("readySeen", 1'b0, readySeen)
      `CHK("retrySeen", 1'b1, retrySeen)
      `CHK("faultSeen", 1'b1, faultSeen)
      $display("test_fast_access done");
   endtask : test_fast_access
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   initial begin
      tick(6);
      rst = 1'b0;
      tick(4);
      test_straps();
      test_strap_setup();
      test_clock();
      test_access();
      test_fast_access();
      report_and_stop();
   end
   initial begin
      #20000;
      nErrors++;
      report_and_stop();
   end
endmodule : local_bus_strap_and_cycle_sampling_tb_top

// ---- logic/lbs_pkg.sv ----
// Types for the local bus strap and cycle sampling block.
// Assumes inclusion of lbs_regs.svh where constants are needed.
package lbs_pkg;
   typedef enum logic [1:0] {LBS_IDLE, LBS_ROW, LBS_COL} lbs_phase_t;
endpackage : lbs_pkg

// ---- logic/lbs_regs.svh ----
// Constants for the local bus strap and cycle sampling block.
// Assumes one system clock whose period equals one output-clock half-cycle.
`ifndef LBS_REGS_SVH
`define LBS_REGS_SVH
`define LBS_CLK_PERIOD_NS 10
`define LBS_RESET_MIN_HALF 6
`define LBS_STRAP_SETUP_HALF 4
`define LBS_ADDR_SHIFT_W 2
`define LBS_BUS_SIZE_W 2
`define LBS_CYCLE_TIMING_W 3
`define LBS_PAGE_SIZE_W 4
`define LBS_CYC_TIMING_TWO 3'h2
`define LBS_CYC_TIMING_THREE 3'h3
`define LBS_ROW_LAST 4'h6
`endif

// ---- logic/lbs_sampler.sv ----
// Behaviour
// - Host request strap low selects self-bootstrap
// - User timing strap low selects big-endian
// - Config inputs sampled at row state two
// - Retry ready fault sampled at row three
// - Ready resampled row six, columns, 2/3-cycle
// - Retry sampled every falling edge after row three
// - Every state starts at output clock fall
// - Output clock period is two system clocks
//
// Strap capture, output clock and per-state input sampling of the local bus.
// Assumes sys_clk is the input clock; pins pass two flops; accessStart and
// colStart come from the same-clock access sequencer and are one-cycle pulses
// aligned to the output clock falling edge.
`timescale 1ns/1ps
`include "lbs_regs.svh"
module lbs_sampler #(
   parameter int ROW_STATES = 6
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic resetPin_n,
   input wire logic hostRequestStrap_n,
   input wire logic userTimingInput_n,
   input wire logic [`LBS_ADDR_SHIFT_W-1:0] addressShiftSelect,
   input wire logic [`LBS_BUS_SIZE_W-1:0] busSizeSelect,
   input wire logic [`LBS_CYCLE_TIMING_W-1:0] cycleTimingSelect,
   input wire logic [`LBS_PAGE_SIZE_W-1:0] pageSizeSelect,
   input wire logic retryIn,
   input wire logic readyIn,
   input wire logic faultIn,
   input wire logic accessStart,
   input wire logic colStart,
   output logic outputClock,
   output logic selfBootstrap,
   output logic bigEndian,
   output logic rowStateTwo,
   output logic [`LBS_ADDR_SHIFT_W-1:0] addrShiftCfg,
   output logic [`LBS_BUS_SIZE_W-1:0] busSizeCfg,
   output logic [`LBS_CYCLE_TIMING_W-1:0] cycleTimingCfg,
   output logic [`LBS_PAGE_SIZE_W-1:0] pageSizeCfg,
   output logic userTimingCfg,
   output logic retrySeen,
   output logic readySeen,
   output logic faultSeen,
   output logic cfgValid
);
   localparam int PIN_W = 3 + `LBS_ADDR_SHIFT_W + `LBS_BUS_SIZE_W + `LBS_CYCLE_TIMING_W
                          + `LBS_PAGE_SIZE_W + 3;
   if (ROW_STATES < 6 || ROW_STATES > 15) begin : g_bad_rows
      $error("ROW_STATES must be 6..15");
   end

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic [PIN_W-1:0] pinSync;
   logic resetS_n, hostReqS_n, userTimeS_n, retryS, readyS, faultS;
   logic [`LBS_ADDR_SHIFT_W-1:0] addrShiftS;
   logic [`LBS_BUS_SIZE_W-1:0] busSizeS;
   logic [`LBS_CYCLE_TIMING_W-1:0] cycTimingS;
   logic [`LBS_PAGE_SIZE_W-1:0] pageSizeS;
   lbs_sync2 #(.WIDTH(PIN_W)) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .asyncIn({resetPin_n, hostRequestStrap_n, userTimingInput_n, addressShiftSelect,
                busSizeSelect, cycleTimingSelect, pageSizeSelect, retryIn, readyIn, faultIn}),
      .syncOut(pinSync)
   );
   assign {resetS_n, hostReqS_n, userTimeS_n, addrShiftS, busSizeS, cycTimingS, pageSizeS, retryS, readyS,
           faultS} = pinSync;

   // -----------------------------------------------------------------
   // Output clock
   // -----------------------------------------------------------------
   // divide by two
   always_ff @(posedge sys_clk) begin
      if (rst) outputClock <= 1'b1;
      else outputClock <= ~outputClock;
   end
   // fall happens when clock high now
   logic fallEdge;
   assign fallEdge = outputClock;

   // -----------------------------------------------------------------
   // Reset pin and strap capture
   // -----------------------------------------------------------------
   logic [2:0] lowCnt_r;
   logic [2:0] hostReqCnt_r;
   logic [2:0] userTimeCnt_r;
   logic resetPrev_r;
   logic resetValid_r;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lowCnt_r <= 3'h0;
         hostReqCnt_r <= 3'h0;
         userTimeCnt_r <= 3'h0;
         resetPrev_r <= 1'b0;
      end else begin
         resetPrev_r <= resetS_n;
         if (resetS_n) lowCnt_r <= 3'h0;
         else if (lowCnt_r != 3'h7) lowCnt_r <= lowCnt_r + 3'h1;
         if (hostReqS_n) hostReqCnt_r <= 3'h0;
         else if (hostReqCnt_r != 3'h7) hostReqCnt_r <= hostReqCnt_r + 3'h1;
         if (userTimeS_n) userTimeCnt_r <= 3'h0;
         else if (userTimeCnt_r != 3'h7) userTimeCnt_r <= userTimeCnt_r + 3'h1;
      end
   end
   logic resetRise;
   assign resetRise = resetS_n && !resetPrev_r;
   always_ff @(posedge sys_clk) begin
      if (rst) resetValid_r <= 1'b0;
      else if (!resetS_n && lowCnt_r >= 3'(`LBS_RESET_MIN_HALF - 1)) resetValid_r <= 1'b1;
      else if (resetRise) resetValid_r <= 1'b0;
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         selfBootstrap <= 1'b0;
         bigEndian <= 1'b0;
      end else if (resetRise && resetValid_r) begin
         selfBootstrap <= !hostReqS_n && hostReqCnt_r >= 3'(`LBS_STRAP_SETUP_HALF);
         bigEndian <= !userTimeS_n && userTimeCnt_r >= 3'(`LBS_STRAP_SETUP_HALF);
      end
   end

   // -----------------------------------------------------------------
   // Access state tracking
   // -----------------------------------------------------------------
   lbs_pkg::lbs_phase_t phase_r;
   logic [3:0] rowState_r;
   always_ff @(posedge sys_clk) begin
      if (rst || !resetS_n) begin
         phase_r <= lbs_pkg::LBS_IDLE;
         rowState_r <= 4'h0;
      end else if (fallEdge) begin
         unique case (phase_r)
            lbs_pkg::LBS_IDLE: begin
               if (accessStart) begin
                  phase_r <= lbs_pkg::LBS_ROW;
                  rowState_r <= 4'h1;
               end
            end
            lbs_pkg::LBS_ROW: begin
               if (rowState_r == 4'(ROW_STATES)) phase_r <= lbs_pkg::LBS_COL;
               else rowState_r <= rowState_r + 4'h1;
            end
            lbs_pkg::LBS_COL: begin
               if (accessStart) begin
                  phase_r <= lbs_pkg::LBS_ROW;
                  rowState_r <= 4'h1;
               end else if (!colStart) phase_r <= lbs_pkg::LBS_IDLE;
            end
            default: phase_r <= lbs_pkg::LBS_IDLE;
         endcase
      end
   end
   // Fall that opens the row state after k
   function automatic logic rowFall(input logic fall, input lbs_pkg::lbs_phase_t ph, input logic [3:0] st,
                                    input logic [3:0] k);
      return fall && ph == lbs_pkg::LBS_ROW && st == k;
   endfunction : rowFall
   logic atRowTwo, atRowThree, atRowSix, pastRowThree, multiCyc;
   assign atRowTwo = rowFall(fallEdge, phase_r, rowState_r, 4'h1);
   assign atRowThree = rowFall(fallEdge, phase_r, rowState_r, 4'h2);
   assign atRowSix = rowFall(fallEdge, phase_r, rowState_r, 4'h5);
   assign pastRowThree = fallEdge && ((phase_r == lbs_pkg::LBS_ROW && rowState_r >= 4'h3)
                                     || phase_r == lbs_pkg::LBS_COL);
   assign multiCyc = cycleTimingCfg == `LBS_CYC_TIMING_TWO || cycleTimingCfg == `LBS_CYC_TIMING_THREE;

   // -----------------------------------------------------------------
   // Configuration sampling
   // -----------------------------------------------------------------
   // sample once, hold for access
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         addrShiftCfg <= '0;
         busSizeCfg <= '0;
         cycleTimingCfg <= '0;
         pageSizeCfg <= '0;
         userTimingCfg <= 1'b0;
         rowStateTwo <= 1'b0;
         cfgValid <= 1'b0;
      end else begin
         rowStateTwo <= atRowTwo;
         if (atRowTwo) begin
            addrShiftCfg <= addrShiftS;
            busSizeCfg <= busSizeS;
            cycleTimingCfg <= cycTimingS;
            pageSizeCfg <= pageSizeS;
            userTimingCfg <= userTimeS_n;
            cfgValid <= 1'b1;
         end else if (phase_r == lbs_pkg::LBS_IDLE) cfgValid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Completion sampling
   // -----------------------------------------------------------------
   // completion input sampling
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         retrySeen <= 1'b0;
         readySeen <= 1'b0;
         faultSeen <= 1'b0;
      end else begin
         if (atRowThree || pastRowThree) retrySeen <= retryS;
         if (atRowThree) faultSeen <= faultS;
         if (atRowThree || (multiCyc && (atRowSix || (fallEdge && phase_r == lbs_pkg::LBS_COL && colStart))))
            readySeen <= readyS;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   sequence s_clk_low_high;
      !outputClock ##1 outputClock;
   endsequence
   property p_clk_div;
      @(posedge sys_clk) disable iff (rst) outputClock |=> s_clk_low_high;
   endproperty
   a_clk_div: assert property (p_clk_div) else $error("output clock not divided by two");
   property p_cfg_hold;
      @(posedge sys_clk) disable iff (rst) !atRowTwo |=> $stable(cycleTimingCfg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed outside row two");
   property p_cfg_take;
      @(posedge sys_clk) disable iff (rst) atRowTwo |=> cycleTimingCfg == $past(cycTimingS) && rowStateTwo;
   endproperty
   a_cfg_take: assert property (p_cfg_take) else $error("config not sampled at row two");
   property p_strap_hold;
      @(posedge sys_clk) disable iff (rst) !resetRise |=> $stable(selfBootstrap) && $stable(bigEndian);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap changed without reset");
   property p_boot;
      @(posedge sys_clk) disable iff (rst)
         resetRise && resetValid_r && !hostReqS_n && hostReqCnt_r >= 3'h4 |=> selfBootstrap;
   endproperty
   a_boot: assert property (p_boot) else $error("self bootstrap not selected");
   property p_endian;
      @(posedge sys_clk) disable iff (rst)
         resetRise && resetValid_r && !userTimeS_n && userTimeCnt_r >= 3'h4 |=> bigEndian;
   endproperty
   a_endian: assert property (p_endian) else $error("big endian not selected");
   property p_fault;
      @(posedge sys_clk) disable iff (rst) atRowThree |=> faultSeen == $past(faultS);
   endproperty
   a_fault: assert property (p_fault) else $error("fault not sampled at row three");
   property p_retry;
      @(posedge sys_clk) disable iff (rst) pastRowThree |=> retrySeen == $past(retryS);
   endproperty
   a_retry: assert property (p_retry) else $error("retry not sampled after row three");
   property p_ready;
      @(posedge sys_clk) disable iff (rst) atRowSix && multiCyc |=> readySeen == $past(readyS);
   endproperty
   a_ready: assert property (p_ready) else $error("ready not sampled at row six");
   property p_fall;
      @(posedge sys_clk) disable iff (rst)
         !outputClock && resetS_n |=> $stable(rowState_r) && $stable(phase_r);
   endproperty
   a_fall: assert property (p_fall) else $error("state not on falling edge");
endmodule : lbs_sampler

// ---- logic/lbs_sync2.sv ----
// Two flip-flop synchroniser for a bus of pin levels.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
module lbs_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_r;
   if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least 1");
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stage1_r <= '0;
         syncOut <= '0;
      end else begin
         stage1_r <= asyncIn;
         syncOut <= stage1_r;
      end
   end
endmodule : lbs_sync2
